/* fpau_top.sv */
// Fixed-point arithmetic unit with APB register access
`timescale 1ns/1ps
`include "fpau_cfg.svh"
module fpau_top (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`FPAU_AW-1:0] paddr,
    input wire logic [`FPAU_DATA_W-1:0] pwdata,
    output logic [`FPAU_DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic cond_nonzero,
    output logic cond_overflow,
    output logic cond_carry,
    output logic cond_sign,
    output logic unit_busy
);
    import fpau_pkg::*;

    // ****************************************
    // Registers
    // ****************************************
    fpau_state_t state_reg;
    logic [`FPAU_W-1:0] dst_hi_reg;
    logic [`FPAU_W-1:0] dst_lo_reg;
    logic [`FPAU_W-1:0] src_hi_reg;
    logic [`FPAU_W-1:0] src_lo_reg;
    logic [`FPAU_W-1:0] mem_reg;
    logic [`FPAU_BW-1:0] imm_reg;
    logic [`FPAU_FLAGS_W-1:0] flag_reg;
    logic q_neg_reg;
    logic [`FPAU_DATA_W-1:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;

    // ****************************************
    // APB decode
    // ****************************************
    logic busy_w;
    logic pend_w;
    logic acc_w;
    logic wr_w;
    logic sel_cmd, sel_dst_hi, sel_dst_lo, sel_src_hi, sel_src_lo;
    logic sel_mem, sel_imm, sel_flags;
    logic addr_ok;
    logic op_ok;
    logic err_w;
    logic fire_w;
    fpau_op_t op_w;
    logic [`FPAU_DATA_W-1:0] rdata_w;

    assign busy_w = state_reg != ST_IDLE;
    assign pend_w = psel & penable & !pready_reg & !busy_w;
    assign acc_w = psel & penable & pready_reg;
    assign sel_cmd = paddr == `FPAU_OFS_CMD;
    assign sel_dst_hi = paddr == `FPAU_OFS_DST_HI;
    assign sel_dst_lo = paddr == `FPAU_OFS_DST_LO;
    assign sel_src_hi = paddr == `FPAU_OFS_SRC_HI;
    assign sel_src_lo = paddr == `FPAU_OFS_SRC_LO;
    assign sel_mem = paddr == `FPAU_OFS_MEM;
    assign sel_imm = paddr == `FPAU_OFS_IMM;
    assign sel_flags = paddr == `FPAU_OFS_FLAGS;
    assign addr_ok = sel_cmd | sel_dst_hi | sel_dst_lo | sel_src_hi |
                     sel_src_lo | sel_mem | sel_imm | sel_flags;
    assign op_w = fpau_op_t'(pwdata[`FPAU_OP_W-1:0]);
    assign op_ok = pwdata[`FPAU_OP_W-1:0] <= OP_NEGATIVE_COPY;
    assign err_w = !addr_ok | (sel_cmd & pwrite & !op_ok);
    assign wr_w = acc_w & pwrite & !pslverr_reg;
    assign fire_w = wr_w & sel_cmd;

    assign rdata_w =
        sel_cmd ? {{(`FPAU_DATA_W-1){1'b0}}, busy_w} :
        sel_dst_hi ? {{(`FPAU_DATA_W-`FPAU_W){1'b0}}, dst_hi_reg} :
        sel_dst_lo ? {{(`FPAU_DATA_W-`FPAU_W){1'b0}}, dst_lo_reg} :
        sel_src_hi ? {{(`FPAU_DATA_W-`FPAU_W){1'b0}}, src_hi_reg} :
        sel_src_lo ? {{(`FPAU_DATA_W-`FPAU_W){1'b0}}, src_lo_reg} :
        sel_mem ? {{(`FPAU_DATA_W-`FPAU_W){1'b0}}, mem_reg} :
        sel_imm ? {{(`FPAU_DATA_W-`FPAU_BW){1'b0}}, imm_reg} :
        sel_flags ? {{(`FPAU_DATA_W-`FPAU_FLAGS_W){1'b0}}, flag_reg} :
        '0;

    // ****************************************
    // Arithmetic
    // ****************************************
    logic [`FPAU_W-1:0] a16, s16;
    logic c16, o16, sub16;
    logic [`FPAU_DW-1:0] a32, src_pair, dst_pair, s32;
    logic c32, o32;
    logic [`FPAU_BW-1:0] s8;
    logic c8;
    logic signed [`FPAU_DW-1:0] prod;
    logic prod_ovf;

    assign src_pair = {src_hi_reg, src_lo_reg};
    assign dst_pair = {dst_hi_reg, dst_lo_reg};
    assign a16 = (op_w == OP_NEGATE || op_w == OP_ABSOLUTE_COPY ||
                  op_w == OP_NEGATIVE_COPY) ? '0 : dst_hi_reg;
    assign sub16 = op_w != OP_CLAMPED_SUM;
    assign a32 = (op_w == OP_WIDE_NEGATE) ? '0 : dst_pair;
    assign prod = $signed(dst_hi_reg) * $signed(src_hi_reg);
    assign prod_ovf = (prod > `FPAU_PROD_MAX) | (prod < `FPAU_PROD_MIN);

    fpau_addsub #(.W(`FPAU_W)) u_add16 (
        .a(a16),
        .b(op_w == OP_MEM_COMPARE ? mem_reg : src_hi_reg),
        .sub(sub16),
        .sum(s16),
        .carry(c16),
        .ovf(o16)
    );

    fpau_addsub #(.W(`FPAU_DW)) u_add32 (
        .a(a32),
        .b(src_pair),
        .sub(1'b1),
        .sum(s32),
        .carry(c32),
        .ovf(o32)
    );

    fpau_addsub #(.W(`FPAU_BW)) u_add8 (
        .a(dst_hi_reg[`FPAU_BW-1:0]),
        .b(imm_reg),
        .sub(1'b1),
        .sum(s8),
        .carry(c8),
        .ovf()
    );

    // ****************************************
    // Divide
    // ****************************************
    logic [`FPAU_DW-1:0] dmag;
    logic [`FPAU_W-1:0] smag;
    logic div_ovf;
    logic div_start;
    logic div_done;
    logic [`FPAU_W-1:0] div_quo, div_rem, quo_signed;

    assign dmag = dst_hi_reg[`FPAU_W-1] ? -dst_pair : dst_pair;
    assign smag = src_hi_reg[`FPAU_W-1] ? -src_hi_reg : src_hi_reg;
    // Quotient must fit a signed word, else it is an overflow
    assign div_ovf = (smag == '0) |
                     (dmag[`FPAU_DW-1:`FPAU_W-1] >= {1'b0, smag});
    assign div_start = fire_w & (op_w == OP_DIVIDE) & !div_ovf;
    assign quo_signed = q_neg_reg ? -div_quo : div_quo;

    fpau_divu #(.W(`FPAU_W)) u_div (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .start(div_start),
        .dividend(dmag),
        .divisor(smag),
        .done(div_done),
        .quotient(div_quo),
        .remainder(div_rem)
    );

    // ****************************************
    // Result and flag selection
    // ****************************************
    logic [`FPAU_W-1:0] res_hi, res_lo, clamp;
    logic wr_hi, wr_lo;
    logic [`FPAU_FLAGS_W-1:0] fl;

    assign clamp = dst_hi_reg[`FPAU_W-1] ? `FPAU_NEG_MIN : `FPAU_POS_MAX;

    always_comb begin
        res_hi = s16;
        res_lo = s32[`FPAU_W-1:0];
        wr_hi = 1'b0;
        wr_lo = 1'b0;
        fl = flag_reg;
        unique case (op_w)
            OP_INT_PRODUCT_LOW: begin
                res_hi = prod[`FPAU_W-1:0];
                wr_hi = 1'b1;
                fl[`FPAU_FLAG_N] = prod != '0;
                fl[`FPAU_FLAG_V] = prod_ovf;
                fl[`FPAU_FLAG_L] = 1'b0;
                fl[`FPAU_FLAG_M] = prod[`FPAU_W-1];
            end
            OP_DIVIDE: begin
                fl[`FPAU_FLAG_V] = div_ovf ? 1'b1 : flag_reg[`FPAU_FLAG_V];
                fl[`FPAU_FLAG_L] = div_ovf ? 1'b0 : flag_reg[`FPAU_FLAG_L];
            end
            OP_REG_COPY: begin
                res_hi = src_hi_reg;
                wr_hi = 1'b1;
                fl[`FPAU_FLAG_N] = src_hi_reg != '0;
                fl[`FPAU_FLAG_M] = src_hi_reg[`FPAU_W-1];
            end
            OP_BYTE_COPY_SEXT: begin
                res_hi = {{(`FPAU_W-`FPAU_BW){src_hi_reg[`FPAU_BW-1]}},
                          src_hi_reg[`FPAU_BW-1:0]};
                wr_hi = 1'b1;
                fl[`FPAU_FLAG_N] = src_hi_reg[`FPAU_BW-1:0] != '0;
                fl[`FPAU_FLAG_M] = src_hi_reg[`FPAU_BW-1];
            end
            OP_LITERAL_LOAD_SEXT: begin
                res_hi = {{(`FPAU_W-`FPAU_BW){imm_reg[`FPAU_BW-1]}},
                          imm_reg};
                wr_hi = 1'b1;
                fl[`FPAU_FLAG_N] = imm_reg != '0;
                fl[`FPAU_FLAG_M] = imm_reg[`FPAU_BW-1];
            end
            OP_NEGATE: begin
                wr_hi = 1'b1;
                fl = {s16 != '0, o16, c16, s16[`FPAU_W-1]};
            end
            OP_WIDE_NEGATE: begin
                res_hi = s32[`FPAU_DW-1:`FPAU_W];
                wr_hi = 1'b1;
                wr_lo = 1'b1;
                fl = {s32 != '0, o32, c32, s32[`FPAU_DW-1]};
            end
            OP_ARITH_COMPARE, OP_MEM_COMPARE: begin
                fl = {s16 != '0, o16, c16, s16[`FPAU_W-1]};
            end
            OP_WIDE_COMPARE: begin
                fl = {s32 != '0, o32, c32, s32[`FPAU_DW-1]};
            end
            OP_BYTE_LITERAL_COMPARE: begin
                fl[`FPAU_FLAG_N] = s8 != '0;
                fl[`FPAU_FLAG_L] = c8;
                fl[`FPAU_FLAG_M] = s8[`FPAU_BW-1];
            end
            OP_CLAMPED_SUM, OP_CLAMPED_DIFFERENCE: begin
                res_hi = o16 ? clamp : s16;
                wr_hi = 1'b1;
                fl = {res_hi != '0, 1'b0, 1'b0, res_hi[`FPAU_W-1]};
            end
            OP_ABSOLUTE_COPY: begin
                res_hi = src_hi_reg[`FPAU_W-1] ? s16 : src_hi_reg;
                wr_hi = 1'b1;
                fl = {res_hi != '0, src_hi_reg[`FPAU_W-1] & o16,
                      src_hi_reg[`FPAU_W-1] & c16, res_hi[`FPAU_W-1]};
            end
            OP_NEGATIVE_COPY: begin
                res_hi = src_hi_reg[`FPAU_W-1] ? src_hi_reg : s16;
                wr_hi = 1'b1;
                fl[`FPAU_FLAG_N] = res_hi != '0;
                fl[`FPAU_FLAG_L] = !src_hi_reg[`FPAU_W-1] & c16;
                fl[`FPAU_FLAG_M] = res_hi[`FPAU_W-1];
            end
            default: begin
                fl = flag_reg;
            end
        endcase
    end

    // ****************************************
    // Sequential state
    // ****************************************
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= '0;
        end else begin
            pready_reg <= pend_w;
            pslverr_reg <= pend_w & err_w;
            prdata_reg <= (pend_w & !pwrite & !err_w) ? rdata_w : '0;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            state_reg <= ST_IDLE;
            q_neg_reg <= 1'b0;
        end else if (div_start) begin
            state_reg <= ST_DIVIDE;
            q_neg_reg <= dst_hi_reg[`FPAU_W-1] ^ src_hi_reg[`FPAU_W-1];
        end else if (div_done) begin
            state_reg <= ST_IDLE;
        end
    end

    // Quotient, remainder and flags land on the same edge
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            dst_hi_reg <= `FPAU_RST_WORD;
            dst_lo_reg <= `FPAU_RST_WORD;
            flag_reg <= `FPAU_RST_FLAGS;
        end else if (div_done) begin
            dst_hi_reg <= div_rem;
            dst_lo_reg <= quo_signed;
            flag_reg <= {quo_signed != '0, 1'b0, 1'b0,
                         quo_signed[`FPAU_W-1]};
        end else if (fire_w) begin
            dst_hi_reg <= wr_hi ? res_hi : dst_hi_reg;
            dst_lo_reg <= wr_lo ? res_lo : dst_lo_reg;
            flag_reg <= fl;
        end else if (wr_w) begin
            dst_hi_reg <= sel_dst_hi ? pwdata[`FPAU_W-1:0] : dst_hi_reg;
            dst_lo_reg <= sel_dst_lo ? pwdata[`FPAU_W-1:0] : dst_lo_reg;
            flag_reg <= sel_flags ? pwdata[`FPAU_FLAGS_W-1:0] : flag_reg;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            src_hi_reg <= `FPAU_RST_WORD;
            src_lo_reg <= `FPAU_RST_WORD;
            mem_reg <= `FPAU_RST_WORD;
            imm_reg <= `FPAU_RST_BYTE;
        end else if (wr_w) begin
            src_hi_reg <= sel_src_hi ? pwdata[`FPAU_W-1:0] : src_hi_reg;
            src_lo_reg <= sel_src_lo ? pwdata[`FPAU_W-1:0] : src_lo_reg;
            mem_reg <= sel_mem ? pwdata[`FPAU_W-1:0] : mem_reg;
            imm_reg <= sel_imm ? pwdata[`FPAU_BW-1:0] : imm_reg;
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign cond_nonzero = flag_reg[`FPAU_FLAG_N];
    assign cond_overflow = flag_reg[`FPAU_FLAG_V];
    assign cond_carry = flag_reg[`FPAU_FLAG_L];
    assign cond_sign = flag_reg[`FPAU_FLAG_M];
    assign unit_busy = state_reg == ST_DIVIDE;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!resetn);

    a_int_product_low_low_word: assert property (fire_w && op_w == OP_INT_PRODUCT_LOW
        |=> dst_hi_reg == $past(prod[`FPAU_W-1:0]) && !cond_carry &&
            cond_sign == dst_hi_reg[`FPAU_W-1])
        else $error("integer product low word or flags wrong");
    a_int_product_low_range_flags: assert property (fire_w && op_w == OP_INT_PRODUCT_LOW
        |=> cond_overflow == ($past(prod) > `FPAU_PROD_MAX ||
            $past(prod) < `FPAU_PROD_MIN) &&
            cond_nonzero == ($past(prod) != '0))
        else $error("integer product overflow or nonzero flag wrong");
    a_int_product_low_keeps_regs: assert property (fire_w && op_w == OP_INT_PRODUCT_LOW
        |=> $stable(dst_lo_reg) && $stable(src_hi_reg))
        else $error("integer product disturbed a kept register");
    a_div_completes: assert property (div_start
        |=> unit_busy [*8] ##[9:10] (!unit_busy && !cond_carry &&
            cond_sign == dst_lo_reg[`FPAU_W-1]))
        else $error("divide did not complete with correct flags");
    a_div_zero_ovf: assert property (fire_w && op_w == OP_DIVIDE &&
        src_hi_reg == '0 |=> cond_overflow && !unit_busy &&
        $stable(dst_pair))
        else $error("divide by zero not flagged");
    a_copy_keeps_vl: assert property (fire_w && op_w == OP_REG_COPY
        |=> dst_hi_reg == $past(src_hi_reg) && $stable(cond_overflow) &&
            $stable(cond_carry))
        else $error("register copy wrong");
    a_byte_sext: assert property (fire_w && op_w == OP_BYTE_COPY_SEXT
        |=> dst_hi_reg[`FPAU_W-1:`FPAU_BW] ==
            {(`FPAU_W-`FPAU_BW){dst_hi_reg[`FPAU_BW-1]}})
        else $error("byte copy not sign extended");
    a_literal_load: assert property (fire_w && op_w == OP_LITERAL_LOAD_SEXT
        |=> dst_hi_reg[`FPAU_BW-1:0] == $past(imm_reg) &&
            cond_nonzero == ($past(imm_reg) != '0))
        else $error("literal load wrong");
    a_negate_min: assert property (fire_w && op_w == OP_NEGATE &&
        src_hi_reg == `FPAU_NEG_MIN |=> dst_hi_reg == `FPAU_NEG_MIN &&
        cond_overflow)
        else $error("negate of most negative value wrong");
    a_wide_neg_ovf: assert property (fire_w && op_w == OP_WIDE_NEGATE
        |=> cond_overflow == ($past(src_pair) == `FPAU_NEG_MIN32))
        else $error("double negate overflow wrong");
    a_compare_no_write: assert property (fire_w &&
        (op_w == OP_ARITH_COMPARE || op_w == OP_MEM_COMPARE ||
         op_w == OP_WIDE_COMPARE || op_w == OP_BYTE_LITERAL_COMPARE)
        |=> $stable(dst_pair) && $stable(src_pair))
        else $error("compare changed a register");
    a_clamped_flags: assert property (fire_w && (op_w == OP_CLAMPED_SUM ||
        op_w == OP_CLAMPED_DIFFERENCE) |=> !cond_overflow && !cond_carry &&
        cond_sign == dst_hi_reg[`FPAU_W-1])
        else $error("clamped operation flags wrong");
    a_clamped_sum_max: assert property (fire_w && op_w == OP_CLAMPED_SUM &&
        !dst_hi_reg[`FPAU_W-1] && !src_hi_reg[`FPAU_W-1] && s16[`FPAU_W-1]
        |=> dst_hi_reg == `FPAU_POS_MAX)
        else $error("clamped sum did not saturate high");
    a_abs_positive: assert property (fire_w && op_w == OP_ABSOLUTE_COPY
        |=> !dst_hi_reg[`FPAU_W-1] || cond_overflow)
        else $error("absolute copy left a negative value");

    c_int_product_low_overflow: cover property (fire_w &&
        op_w == OP_INT_PRODUCT_LOW && prod_ovf);
    c_div_done: cover property (div_done);
    c_clamp_hit: cover property (fire_w && op_w == OP_CLAMPED_DIFFERENCE &&
        o16);
    c_wide_compare: cover property (fire_w && op_w == OP_WIDE_COMPARE);
endmodule

/* fpau_cfg.svh */
// Constants of the fixed-point arithmetic unit
// Notes on behaviour
// - Integer product keeps low 16 product bits in destination; carry cleared, sign is bit 15.
// - Integer product sets overflow outside signed 16-bit range; nonzero cleared for zero.
// - Integer product leaves source and destination pair second word untouched.
// - Divide: 32-bit pair by source; quotient to second word, remainder magnitude first.
// - Divide overflow on zero or too small divisor; carry cleared, sign from quotient.
// - Register copy moves source unchanged; nonzero and sign follow, overflow and carry kept.
// - Byte copy sign-extends source low byte from bit 7; overflow and carry kept.
// - Literal load sign-extends literal from bit 7; nonzero clear only for zero literal.
// - Negate: two's complement, 8000 stays 8000 with overflow; carry out; sign bit 15.
// - Double negate complements pair; overflow only for 8000 0000; sign is bit 31.
// - Word compare subtracts source from destination for flags only, no register change.
// - Memory compare subtracts memory word from destination for flags only.
// - Double compare subtracts pairs for flags only, flags as double subtract.
// - Byte literal compare on low byte; sign bit 7, carry from subtract, overflow kept.
// - Clamped sum saturates to 7FFF or 8000 on overflow, else stores sum.
// - Clamped difference saturates to 8000 or 7FFF on overflow, else stores difference.
// - Absolute copy negates negative source; overflow only for 8000; source preserved.
// - Negative copy negates positive source; overflow kept; carry from negation; sign bit 15.
// - Double subtract flags: nonzero unless both words zero; sign is upper word bit 15.
`ifndef FPAU_CFG_SVH
`define FPAU_CFG_SVH

`define FPAU_W 16
`define FPAU_DW 32
`define FPAU_BW 8
`define FPAU_OP_W 4
`define FPAU_AW 8
`define FPAU_DATA_W 32

`define FPAU_OFS_CMD 8'h00
`define FPAU_OFS_DST_HI 8'h04
`define FPAU_OFS_DST_LO 8'h08
`define FPAU_OFS_SRC_HI 8'h0c
`define FPAU_OFS_SRC_LO 8'h10
`define FPAU_OFS_MEM 8'h14
`define FPAU_OFS_IMM 8'h18
`define FPAU_OFS_FLAGS 8'h1c

`define FPAU_FLAG_N 3
`define FPAU_FLAG_V 2
`define FPAU_FLAG_L 1
`define FPAU_FLAG_M 0
`define FPAU_FLAGS_W 4

`define FPAU_RST_WORD 16'h0000
`define FPAU_RST_BYTE 8'h00
`define FPAU_RST_FLAGS 4'h0
`define FPAU_POS_MAX 16'h7fff
`define FPAU_NEG_MIN 16'h8000
`define FPAU_NEG_MIN32 32'h8000_0000
`define FPAU_PROD_MAX 32'sh0000_7fff
`define FPAU_PROD_MIN (-32'sh0000_8000)

`endif

/* fpau_pkg.sv */
// Types of the fixed-point arithmetic unit
package fpau_pkg;

    typedef enum logic [3:0] {
        OP_INT_PRODUCT_LOW     = 4'h0,
        OP_DIVIDE              = 4'h1,
        OP_REG_COPY            = 4'h2,
        OP_BYTE_COPY_SEXT      = 4'h3,
        OP_LITERAL_LOAD_SEXT   = 4'h4,
        OP_NEGATE              = 4'h5,
        OP_WIDE_NEGATE         = 4'h6,
        OP_ARITH_COMPARE       = 4'h7,
        OP_MEM_COMPARE         = 4'h8,
        OP_WIDE_COMPARE        = 4'h9,
        OP_BYTE_LITERAL_COMPARE = 4'ha,
        OP_CLAMPED_SUM         = 4'hb,
        OP_CLAMPED_DIFFERENCE  = 4'hc,
        OP_ABSOLUTE_COPY       = 4'hd,
        OP_NEGATIVE_COPY       = 4'he
    } fpau_op_t;

    typedef enum logic [0:0] {
        ST_IDLE   = 1'b0,
        ST_DIVIDE = 1'b1
    } fpau_state_t;

endpackage

/* fpau_addsub.sv */
// Adder and subtractor with carry out and signed overflow
`timescale 1ns/1ps
`include "fpau_cfg.svh"
module fpau_addsub #(
    parameter int W = `FPAU_W
) (
    input wire logic [W-1:0] a,
    input wire logic [W-1:0] b,
    input wire logic sub,
    output logic [W-1:0] sum,
    output logic carry,
    output logic ovf
);
    logic [W-1:0] b_eff;

    // Subtract adds the inverted operand plus one; carry means no borrow
    assign b_eff = sub ? ~b : b;
    assign {carry, sum} = {1'b0, a} + {1'b0, b_eff} + {{W{1'b0}}, sub};
    assign ovf = (a[W-1] == b_eff[W-1]) & (sum[W-1] != a[W-1]);
endmodule

/* fpau_divu.sv */
// Unsigned restoring divider, one quotient bit per clock
`timescale 1ns/1ps
`include "fpau_cfg.svh"
module fpau_divu #(
    parameter int W = `FPAU_W
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic start,
    input wire logic [2*W-1:0] dividend,
    input wire logic [W-1:0] divisor,
    output logic done,
    output logic [W-1:0] quotient,
    output logic [W-1:0] remainder
);
    localparam int CW = $clog2(W + 1);
    logic [CW-1:0] cnt_reg;
    logic [W-1:0] rem_reg;
    logic [W-1:0] low_reg;
    logic [W-1:0] dsr_reg;
    logic done_reg;
    logic [W:0] trial;
    logic [W:0] diff;
    logic fits;

    // Caller guarantees the upper dividend half is below the divisor
    assign trial = {rem_reg, low_reg[W-1]};
    assign fits = trial >= {1'b0, dsr_reg};
    assign diff = trial - {1'b0, dsr_reg};
    assign done = done_reg;
    assign quotient = low_reg;
    assign remainder = rem_reg;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            cnt_reg <= '0;
            rem_reg <= '0;
            low_reg <= '0;
            dsr_reg <= '0;
            done_reg <= 1'b0;
        end else begin
            done_reg <= (cnt_reg == CW'(1)) & !start;
            if (start) begin
                cnt_reg <= CW'(W);
                rem_reg <= dividend[2*W-1:W];
                low_reg <= dividend[W-1:0];
                dsr_reg <= divisor;
            end else if (cnt_reg != '0) begin
                rem_reg <= fits ? diff[W-1:0] : trial[W-1:0];
                low_reg <= {low_reg[W-2:0], fits};
                cnt_reg <= cnt_reg - CW'(1);
            end
        end
    end
endmodule

/* fpau_seq.sv */
// APB master model standing in for the processor sequencer
`timescale 1ns/1ps
module fpau_seq (
    input wire logic clk_sys,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [31:0] prdata,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata
);
    logic [31:0] rd = 32'h0;
    logic err = 1'b0;
    logic hung = 1'b0;
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end
    // One transfer; request held until pready is seen at an edge
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d);
        int n;
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        // Look mid-cycle so the answer is settled; it is taken at that same negedge
        do begin
            @(negedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 40);
        hung = (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        @(posedge clk_sys);
        psel <= 1'b0;
        penable <= 1'b0;
        pwdata <= ~d;
    endtask
endmodule

/* fpau_top_bench.sv */
// Self-checking bench of the fixed-point arithmetic unit
`timescale 1ns/1ps
`include "fpau_cfg.svh"
module fpau_top_bench;
    typedef struct packed {
        logic [3:0] op;
        logic [15:0] a, al, b, bl, eh, el;
        logic [3:0] f;
    } fpau_row_t;
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, busy;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] flg;
    int mismatches = 0;
    int n_tests = 0;
    // Operation, dst pair, src pair, expected dst pair, expected flags
    fpau_row_t rows [23] = '{
        104'h0_007a_1234_0011_0000_081a_1234_8,
        104'h0_0100_1234_0100_0000_0000_1234_c,
        104'h1_0000_1000_0007_0000_0001_0249_8,
        104'h1_ffff_f000_0007_0000_0001_fdb7_9,
        104'h1_0000_7fff_0001_0000_0000_7fff_8,
        104'h1_0000_8000_0001_0000_0000_8000_4,
        104'h1_0000_1000_0000_0000_0000_1000_4,
        104'h2_0000_1234_8001_0000_8001_1234_f,
        104'h3_0000_1234_1280_0000_ff80_1234_f,
        104'h4_0000_1234_007f_0000_007f_1234_e,
        104'h5_0000_1234_8000_0000_8000_1234_d,
        104'h5_0000_1234_0000_0000_0000_1234_2,
        104'h6_0000_0000_0000_0001_ffff_ffff_9,
        104'h6_0000_0000_8000_0000_8000_0000_d,
        104'h7_8000_1234_0001_0000_8000_1234_e,
        104'h8_01b3_1234_0f5a_0000_01b3_1234_9,
        104'h9_0001_0000_0000_0001_0001_0000_a,
        104'ha_1241_1234_0041_0000_1241_1234_6,
        104'hb_74a5_1234_3000_0000_7fff_1234_8,
        104'hc_8b5b_1234_3000_0000_8000_1234_9,
        104'hd_0000_1234_ffa5_0000_005b_1234_8,
        104'he_0000_1234_00a5_0000_ff5b_1234_d,
        104'he_0000_1234_0000_0000_0000_1234_6
    };
    always #12.5 clk_sys = ~clk_sys;
    fpau_top fpau_top_i (.clk_sys(clk_sys), .resetn(resetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .cond_nonzero(flg[3]), .cond_overflow(flg[2]), .cond_carry(flg[1]),
        .cond_sign(flg[0]), .unit_busy(busy));
    fpau_seq fpau_seq_i (.clk_sys(clk_sys), .pready(pready),
        .pslverr(pslverr), .prdata(prdata), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
    task automatic stop_test();
        $display("mismatches %0d n_tests %0d", mismatches, n_tests);
        if (mismatches == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        fpau_seq_i.xfer(w, a, d);
        if (fpau_seq_i.hung) begin
            mismatches++;
            $display("[FAIL] %0t bus hang", $time);
            stop_test();
        end
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t got %h want %h", $time, got, exp);
        end
    endtask
    initial begin
        repeat (4) @(posedge clk_sys);
        resetn <= 1'b1;
        bus(1'b0, `FPAU_OFS_DST_HI, 32'h0);
        chk(fpau_seq_i.rd, 32'h0);
        foreach (rows[i]) begin
            bus(1'b1, `FPAU_OFS_FLAGS, 32'h6);
            bus(1'b1, `FPAU_OFS_DST_HI, {16'h0, rows[i].a});
            bus(1'b1, `FPAU_OFS_DST_LO, {16'h0, rows[i].al});
            bus(1'b1, `FPAU_OFS_SRC_HI, {16'h0, rows[i].b});
            bus(1'b1, `FPAU_OFS_SRC_LO, {16'h0, rows[i].bl});
            bus(1'b1, `FPAU_OFS_MEM, {16'h0, rows[i].b});
            bus(1'b1, `FPAU_OFS_IMM, {24'h0, rows[i].b[7:0]});
            bus(1'b1, `FPAU_OFS_CMD, {28'h0, rows[i].op});
            @(negedge clk_sys);
            chk({31'h0, busy}, {31'h0, rows[i].op == 4'h1 && !rows[i].f[2]});
            bus(1'b0, `FPAU_OFS_DST_HI, 32'h0);
            chk(fpau_seq_i.rd, {16'h0, rows[i].eh});
            bus(1'b0, `FPAU_OFS_DST_LO, 32'h0);
            chk(fpau_seq_i.rd, {16'h0, rows[i].el});
            chk({28'h0, flg}, {28'h0, rows[i].f});
        end
        bus(1'b1, 8'h20, 32'h1);
        chk({31'h0, fpau_seq_i.err}, 32'h1);
        bus(1'b1, `FPAU_OFS_CMD, 32'hf);
        chk({31'h0, fpau_seq_i.err}, 32'h1);
        chk({28'h0, flg}, 32'h6);
        stop_test();
    end
endmodule
